// file: pkg/cwpd_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package cwpd_pkg;
    localparam logic [15:0] ADDR_REV   = 16'h8005;
    localparam logic [15:0] ADDR_PART  = 16'h8006;
    localparam logic [15:0] ADDR_RSVD  = 16'h8009;
    localparam logic [15:0] ADDR_PART4 = 16'h800a;
    localparam logic [15:0] ADDR_CP5   = 16'h800b;
    localparam logic [15:0] ADDR_CTRL  = 16'h8010;
    localparam logic [15:0] ADDR_STAT  = 16'h8011;
    localparam logic [15:0] ADDR_PFM_LAST = 16'h0fff;
    localparam logic [15:0] SAF_WORDS  = 16'h0080;
    localparam logic [15:0] PFM_HALF_END = 16'h07ff;
    localparam int BIT_LVP = 13;
    localparam int BIT_WSAF = 11;
    localparam int BIT_WCFG = 9;
    localparam int BIT_WBOOT = 8;
    localparam int BIT_WAPP = 7;
    localparam int BIT_STORAGE_AREA_ENABLE_N_N = 4;
    localparam int BIT_BOOT_REGION_ENABLE_N_N = 3;
    localparam int BIT_CP_N = 0;
    localparam logic [13:0] CFG4_RESET = 14'h3fff;
    localparam logic [13:0] CFG5_RESET = 14'h3fff;
    localparam logic [13:0] CFG4_ONES_MASK = 14'h2a98;
    localparam logic [13:0] CFG4_SIZE_MASK = 14'h0007;
    localparam logic [11:0] PART_CODE  = 12'h5a5; // Arbitrary value
    localparam logic [5:0]  MAJOR_REV  = 6'h01;   // Arbitrary value
    localparam logic [5:0]  MINOR_REV  = 6'h00;   // Arbitrary value
    localparam int CLK_MHZ = 50;
    localparam int DELAY_LONG_MS = 16;
    localparam int DELAY_SHORT_MS = 1;
    localparam int DELAY_LONG_CYC = DELAY_LONG_MS * CLK_MHZ * 1000;
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * CLK_MHZ * 1000;
    typedef struct packed {
        logic        ext;      // External access (programmer)
        logic        wr;
        logic        rd;
        logic [15:0] addr;
    } cwpd_acc_t;
endpackage : cwpd_pkg

// file: rtl/cwpd_top.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module cwpd_top (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Register port
    input  wire logic [15:0]       reg_addr,
    input  wire logic [13:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [13:0]       reg_rdata_ff,
    // Nonvolatile copies, loaded after reset release; erase and LVP session inputs
    input  wire logic [13:0]       nv_cfg4,
    input  wire logic [13:0]       nv_cfg5,
    input  wire logic              bulk_erase,
    input  wire logic              lvp_session,
    // Memory access check
    input  wire cwpd_pkg::cwpd_acc_t acc,
    input  wire logic [13:0]       mem_rdata,
    output logic                   acc_allow_ff,
    output logic      [13:0]       acc_rdata_ff,
    output logic                   write_error_flag_ff,
    // Decoded outputs
    output logic                   reset_pin_role_ff,
    output logic [1:0]             powerup_delay_select_ff,
    output logic                   code_protect_ff,
    output logic [15:0]            boot_end_ff,
    output logic                   boot_enabled_ff,
    output logic                   storage_enabled_ff,
    output logic [15:0]            storage_base_ff,
    output logic                   fetch_ok_ff
);
    logic [13:0] cfg4_ff, cfg5_ff, nxt_cfg4, nxt_cfg5;
    logic [1:0]  dly_ff;
    logic        load_ff;
    logic        ctl_reset_pin_enable_ff;

    //--------------------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------------------
    // Config word enable and protect bits
    wire logic low_voltage_programming     = cfg4_ff[cwpd_pkg::BIT_LVP];
    wire logic boot_en = ~cfg4_ff[cwpd_pkg::BIT_BOOT_REGION_ENABLE_N_N];
    wire logic saf_en  = ~cfg4_ff[cwpd_pkg::BIT_STORAGE_AREA_ENABLE_N_N];
    wire logic cp_on   = ~cfg5_ff[cwpd_pkg::BIT_CP_N];
    wire logic cfg_wp  = ~cfg4_ff[cwpd_pkg::BIT_WCFG];
    // Raw end from size code, then clamp to half memory
    logic [15:0] raw_end;
    always_comb begin
        unique case (cfg4_ff[2:0])
            3'h7:    raw_end = 16'h01ff;
            3'h6:    raw_end = 16'h03ff;
            3'h5:    raw_end = 16'h07ff;
            3'h4:    raw_end = 16'h0fff;
            3'h3:    raw_end = 16'h1fff;
            default: raw_end = 16'h3fff;
        endcase
    end
    wire logic [15:0] boot_end = (raw_end > cwpd_pkg::PFM_HALF_END) ?
                                 cwpd_pkg::PFM_HALF_END : raw_end;
    wire logic [15:0] saf_base = cwpd_pkg::ADDR_PFM_LAST - cwpd_pkg::SAF_WORDS
                                 + 16'h0001;
    // Region of the access address
    wire logic is_cfg  = (acc.addr >= 16'h8007) && (acc.addr <= cwpd_pkg::ADDR_CP5);
    wire logic is_pfm  = acc.addr <= cwpd_pkg::ADDR_PFM_LAST;
    wire logic in_boot = is_pfm && boot_en && (acc.addr <= boot_end);
    wire logic in_saf  = is_pfm && saf_en && (acc.addr >= saf_base);
    wire logic in_app  = is_pfm && !in_boot && !in_saf;
    wire logic wp_hit  = (in_saf  && ~cfg4_ff[cwpd_pkg::BIT_WSAF])
                       | (is_cfg  && cfg_wp)
                       | (in_boot && ~cfg4_ff[cwpd_pkg::BIT_WBOOT])
                       | (in_app  && ~cfg4_ff[cwpd_pkg::BIT_WAPP]);
    wire logic cp_block = acc.ext && cp_on && is_pfm;
    wire logic wr_bad  = acc.wr && (wp_hit || cp_block);

    //--------------------------------------------------------------------------
    // Register writes
    //--------------------------------------------------------------------------
    // Protections other than boot write protect (bit 8) may only move to the protected state; bulk erase restores
    wire logic wr4 = reg_wr && reg_addr == cwpd_pkg::ADDR_PART4 && !cfg_wp;
    wire logic wr5 = reg_wr && reg_addr == cwpd_pkg::ADDR_CP5 && !cfg_wp;
    wire logic [13:0] ones_ok = cfg4_ff | ~cwpd_pkg::CFG4_ONES_MASK;
    wire logic [13:0] w4a = (reg_wdata & ones_ok);
    wire logic [13:0] w4b = boot_en ? ((w4a & ~cwpd_pkg::CFG4_SIZE_MASK)
                          | (cfg4_ff & cwpd_pkg::CFG4_SIZE_MASK)) : w4a;
    wire logic lvp_keep = lvp_session && low_voltage_programming;
    wire logic [13:0] w4c = lvp_keep ? (w4b | 14'h2000) : w4b;
    always_comb begin
        nxt_cfg4 = cfg4_ff;
        nxt_cfg5 = cfg5_ff;
        if (bulk_erase) begin
            nxt_cfg4 = cwpd_pkg::CFG4_RESET;
            nxt_cfg5 = cwpd_pkg::CFG5_RESET;
        end else if (wr4) begin
            nxt_cfg4 = w4c;
        end else if (wr5) begin
            nxt_cfg5 = {cfg5_ff[13:1], reg_wdata[0] & cfg5_ff[0]};
        end
    end

    // Latch nonvolatile copy in the cycle after reset release
    always_ff @(posedge clk) begin
        if (reset) begin
            load_ff <= 1'b1;
            cfg4_ff <= cwpd_pkg::CFG4_RESET;
            cfg5_ff <= cwpd_pkg::CFG5_RESET;
        end else begin
            load_ff <= 1'b0;
            cfg4_ff <= load_ff ? nv_cfg4 : nxt_cfg4;
            cfg5_ff <= load_ff ? nv_cfg5 : nxt_cfg5;
        end
    end

    //--------------------------------------------------------------------------
    // Reads
    //--------------------------------------------------------------------------
    // Identity words are constants; reserved word reads zero
    logic [13:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            cwpd_pkg::ADDR_PART:  rd_mux = {2'h3, cwpd_pkg::PART_CODE};
            cwpd_pkg::ADDR_REV:   rd_mux = {2'h2, cwpd_pkg::MAJOR_REV,
                                            cwpd_pkg::MINOR_REV};
            cwpd_pkg::ADDR_RSVD:  rd_mux = 14'h0000;
            cwpd_pkg::ADDR_PART4: rd_mux = cfg4_ff;
            cwpd_pkg::ADDR_CP5:   rd_mux = cfg5_ff;
            cwpd_pkg::ADDR_STAT:  rd_mux = {11'h000, write_error_flag_ff, low_voltage_programming, cp_on};
            default:              rd_mux = 14'h0000;
        endcase
    end
    wire logic clr_err = reg_wr && reg_addr == cwpd_pkg::ADDR_CTRL && reg_wdata[0];

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    // Delay code held from the control register; the timer itself lives elsewhere
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata_ff            <= 14'h0000;
            acc_allow_ff            <= 1'b0;
            acc_rdata_ff            <= 14'h0000;
            write_error_flag_ff     <= 1'b0;
            reset_pin_role_ff       <= 1'b1;
            powerup_delay_select_ff <= 2'h3;
            code_protect_ff         <= 1'b0;
            boot_end_ff             <= 16'h0000;
            boot_enabled_ff         <= 1'b0;
            storage_enabled_ff      <= 1'b0;
            storage_base_ff         <= 16'h0000;
            fetch_ok_ff             <= 1'b1;
        end else begin
            reg_rdata_ff            <= reg_rd ? rd_mux : 14'h0000;
            acc_allow_ff            <= (acc.wr || acc.rd) && !wr_bad && !cp_block;
            acc_rdata_ff            <= cp_block ? 14'h0000 : mem_rdata;
            write_error_flag_ff     <= wr_bad | (write_error_flag_ff & ~clr_err);
            reset_pin_role_ff       <= low_voltage_programming | ctl_reset_pin_enable_ff;
            powerup_delay_select_ff <= dly_ff;
            code_protect_ff         <= cp_on;
            boot_end_ff             <= boot_en ? boot_end : 16'h0000;
            boot_enabled_ff         <= boot_en;
            storage_enabled_ff      <= saf_en;
            storage_base_ff         <= saf_base;
            fetch_ok_ff             <= !(in_saf && acc.rd && !acc.ext);
        end
    end
    // Reset pin enable and delay code held in control; bit 1 and bits 3:2
    wire logic wr_ctl = reg_wr && reg_addr == cwpd_pkg::ADDR_CTRL;
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_reset_pin_enable_ff <= 1'b1;
            dly_ff       <= 2'h3;
        end else if (wr_ctl) begin
            ctl_reset_pin_enable_ff <= reg_wdata[1];
            dly_ff       <= reg_wdata[3:2];
        end
    end

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    property p_cp_zero;
        @(posedge clk) disable iff (reset) cp_block |=> acc_rdata_ff == 14'h0000;
    endproperty
    a_cp_zero: assert property (p_cp_zero) else $error("protected read not zero");
    property p_err;
        @(posedge clk) disable iff (reset) wr_bad |=> write_error_flag_ff && !acc_allow_ff;
    endproperty
    a_err: assert property (p_err) else $error("bad write not flagged");
    property p_lvp;
        @(posedge clk) disable iff (reset) low_voltage_programming |=> reset_pin_role_ff;
    endproperty
    a_lvp: assert property (p_lvp) else $error("reset role lost");
    property p_clamp;
        @(posedge clk) disable iff (reset) boot_en |=> boot_end_ff <= cwpd_pkg::PFM_HALF_END;
    endproperty
    a_clamp: assert property (p_clamp) else $error("boot too large");
    property p_cp_sticky;
        @(posedge clk) disable iff (reset || load_ff) cp_on && !bulk_erase |=> cp_on;
    endproperty
    a_cp_sticky: assert property (p_cp_sticky) else $error("cp cleared");
    property p_wp_sticky;
        @(posedge clk) disable iff (reset || load_ff)
            !cfg4_ff[cwpd_pkg::BIT_WAPP] && !bulk_erase |=> !cfg4_ff[cwpd_pkg::BIT_WAPP];
    endproperty
    a_wp_sticky: assert property (p_wp_sticky) else $error("wp cleared");
    property p_size;
        @(posedge clk) disable iff (reset || load_ff)
            boot_en && !bulk_erase |=> $stable(cfg4_ff[2:0]);
    endproperty
    a_size: assert property (p_size) else $error("size changed");
    property p_lvp_keep;
        @(posedge clk) disable iff (reset || load_ff)
            low_voltage_programming && lvp_session && !bulk_erase |=> low_voltage_programming;
    endproperty
    a_lvp_keep: assert property (p_lvp_keep) else $error("lvp dropped");
    c_err: cover property (@(posedge clk) wr_bad);
    c_cp: cover property (@(posedge clk) cp_block && acc.rd);
    c_boot: cover property (@(posedge clk) in_boot && acc.wr);
endmodule : cwpd_top

// file: testbench/cwpd_nv_model.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// Flash array stand-in
//------------------------------------------------------------
module cwpd_nv_model (
    // Access seen by the array
    input  wire cwpd_pkg::cwpd_acc_t acc,
    // Read data back to the block
    output logic [13:0]              mem_rdata
);
    // Data follows the address; off a read the inverse shows, never a held value
    assign mem_rdata = acc.rd ? (acc.addr[13:0] ^ 14'h1555) : ~(acc.addr[13:0] ^ 14'h1555);
endmodule : cwpd_nv_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// Bench
//------------------------------------------------------------
module tb_top;
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bulk_erase = 1'b0, lvp_session = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [13:0] reg_wdata = 14'h0000, nv_cfg4 = 14'h3fff, nv_cfg5 = 14'h3fff;
    logic [13:0] reg_rdata_ff, mem_rdata, acc_rdata_ff, v;
    logic [15:0] boot_end_ff, storage_base_ff;
    logic [1:0]  dly;
    logic        allow, err, role, cp, boot_en, saf_en, fetch;
    cwpd_pkg::cwpd_acc_t acc = '0;
    int          failures = 0, compares = 0, cycles = 0;

    cwpd_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .nv_cfg4(nv_cfg4),
        .nv_cfg5(nv_cfg5), .bulk_erase(bulk_erase), .lvp_session(lvp_session), .acc(acc),
        .mem_rdata(mem_rdata), .acc_allow_ff(allow), .acc_rdata_ff(acc_rdata_ff),
        .write_error_flag_ff(err), .reset_pin_role_ff(role), .powerup_delay_select_ff(dly),
        .code_protect_ff(cp), .boot_end_ff(boot_end_ff), .boot_enabled_ff(boot_en),
        .storage_enabled_ff(saf_en), .storage_base_ff(storage_base_ff), .fetch_ok_ff(fetch));
    cwpd_nv_model u_nv (.acc(acc), .mem_rdata(mem_rdata));

    // 20 ns clock; the cycle ceiling cuts a hang short
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [13:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        cyc(2);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_ff;
    endtask : rd
    task automatic access(input logic e, input logic w, input logic [15:0] a);
        @(posedge clk);
        acc <= '{ext: e, wr: w, rd: !w, addr: a};
        @(posedge clk);
        acc <= '0;
        #1;
    endtask : access
    task automatic erase;
        @(posedge clk);
        bulk_erase <= 1'b1;
        @(posedge clk);
        bulk_erase <= 1'b0;
        cyc(2);
    endtask : erase

    // Scenarios
    task automatic t_ids;
        rd(cwpd_pkg::ADDR_PART);
        chk("part", 14'h3000 | cwpd_pkg::PART_CODE, v);
        wr(cwpd_pkg::ADDR_PART, 14'h0000);
        rd(cwpd_pkg::ADDR_PART);
        chk("part ro", 14'h3000 | cwpd_pkg::PART_CODE, v);
        rd(cwpd_pkg::ADDR_REV);
        chk("rev", {2'b10, cwpd_pkg::MAJOR_REV, cwpd_pkg::MINOR_REV}, v);
    endtask : t_ids
    task automatic t_lvp;
        lvp_session <= 1'b1;
        wr(cwpd_pkg::ADDR_PART4, 14'h1fff);
        rd(cwpd_pkg::ADDR_PART4);
        chk("lvp kept", 1'b1, v[13]);
        lvp_session <= 1'b0;
        wr(cwpd_pkg::ADDR_CTRL, 14'h0000);
        chk("role lvp", 1'b1, role);
        wr(cwpd_pkg::ADDR_PART4, 14'h1fff);
        chk("role port", 1'b0, role);
        wr(cwpd_pkg::ADDR_CTRL, 14'h0002);
        chk("role reset", 1'b1, role);
        chk("delay 1ms", 2'b00, dly);
        wr(cwpd_pkg::ADDR_CTRL, 14'h0006);
        chk("delay 16ms", 2'b01, dly);
    endtask : t_lvp
    task automatic t_boot;
        logic [15:0] e;
        for (int i = 0; i < 8; i++) begin
            erase();
            chk("boot off", 1'b0, boot_en);
            wr(cwpd_pkg::ADDR_PART4, 14'h3ff0 | 14'(i));
            e = (i == 7) ? 16'h01ff : (i == 6) ? 16'h03ff : cwpd_pkg::PFM_HALF_END;
            chk("boot end", e, boot_end_ff);
            chk("boot on", 1'b1, boot_en);
        end
        wr(cwpd_pkg::ADDR_PART4, 14'h3ff0);
        chk("size frozen", 16'h01ff, boot_end_ff);
    endtask : t_boot
    task automatic t_saf;
        erase();
        chk("saf off", 1'b0, saf_en);
        wr(cwpd_pkg::ADDR_PART4, 14'h3fef);
        chk("saf on", 1'b1, saf_en);
        chk("saf base", cwpd_pkg::ADDR_PFM_LAST - 16'h007f, storage_base_ff);
        access(1'b0, 1'b0, 16'h0f90);
        chk("saf no fetch", 1'b0, fetch);
        access(1'b0, 1'b0, 16'h0010);
        chk("app fetch", 1'b1, fetch);
    endtask : t_saf
    task automatic t_wprot;
        erase();
        access(1'b0, 1'b1, 16'h0100);
        chk("app open", 1'b1, allow);
        wr(cwpd_pkg::ADDR_PART4, 14'h3f7f);
        wr(cwpd_pkg::ADDR_PART4, 14'h3fff);
        rd(cwpd_pkg::ADDR_PART4);
        chk("wp sticky", 1'b0, v[7]);
        access(1'b0, 1'b1, 16'h0100);
        chk("app blocked", 1'b0, allow);
        cyc(1);
        chk("wr error", 1'b1, err);
        wr(cwpd_pkg::ADDR_CTRL, 14'h0003);
        chk("err clear", 1'b0, err);
        erase();
        wr(cwpd_pkg::ADDR_PART4, 14'h3dff);
        wr(cwpd_pkg::ADDR_PART4, 14'h3def);
        chk("cfg locked", 1'b0, saf_en);
    endtask : t_wprot
    task automatic t_cp;
        erase();
        access(1'b1, 1'b0, 16'h0010);
        chk("ext rd", 14'h0010 ^ 14'h1555, acc_rdata_ff);
        wr(cwpd_pkg::ADDR_CP5, 14'h3ffe);
        chk("cp on", 1'b1, cp);
        access(1'b1, 1'b0, 16'h0010);
        chk("ext rd cp", 14'h0000, acc_rdata_ff);
        access(1'b0, 1'b0, 16'h0010);
        chk("int rd cp", 14'h0010 ^ 14'h1555, acc_rdata_ff);
        access(1'b1, 1'b1, 16'h0010);
        chk("ext wr cp", 1'b0, allow);
        wr(cwpd_pkg::ADDR_CP5, 14'h3fff);
        rd(cwpd_pkg::ADDR_CP5);
        chk("cp sticky", 1'b0, v[0]);
    endtask : t_cp
    task automatic t_nv;
        @(posedge clk);
        nv_cfg4 <= 14'h3ff6;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        cyc(3);
        chk("nv boot", 16'h03ff, boot_end_ff);
    endtask : t_nv

    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Main sequence: two reset cycles, then load edge, then scenarios
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        cyc(3);
        chk("delay reset", 2'h3, dly);
        t_ids();
        t_lvp();
        t_boot();
        t_saf();
        t_wprot();
        t_cp();
        t_nv();
        tally_and_finish();
    end
endmodule : tb_top
